// [core/iqr_mem.sv]
// small two-port sample memory for the input buffer.
// assumes one clock; read data appear one edge after the read strobe, from a register.
module iqr_mem
   import iqr_pkg::*;
(
   input  wire logic           i_clk,
   input  wire logic           i_we,
   input  wire logic [FAW-1:0] i_waddr,
   input  wire iqr_smp_t       i_wdata,
   input  wire logic           i_re,
   input  wire logic [FAW-1:0] i_raddr,
   output iqr_smp_t            o_rdata
);
   iqr_smp_t mem [FDEPTH];

   // no reset on the array itself: contents only matter once written
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      if (i_re) begin
         o_rdata <= mem[i_raddr];
      end
   end
endmodule : iqr_mem

// [core/iqr_pkg.sv]
// package for the receive-direction I/Q sample port: register map, field layout, timing.
// assumes one 10 MHz system clock; only the link pins arrive asynchronously, APB and baseband signals are synchronous.
//
// Contract
// R1 - with both options fitted, a direction bit exists; receive runs only in input.
// R2 - receive-only build: direction bit absent, module is always input.
// R3 - serial, parallel and parallel interleaved port modes, chosen before transfer.
// R4 - input buffer overflow raises error code 803.
// R5 - input buffer underflow raises error code 804.
// R6 - external source takes the sample clock from the external clock pin.
// R7 - device source takes the sample clock from the device connector.
// R8 - internal source builds its own clock from the reference input.
// R9 - rate defines internal clock; for other sources it only declares the rate. Code sets the internal clock from div; rate only declares.
// R10 - other party leaves external clock pin undriven during internal source.
// R11 - coarse phase in 90 degree steps; 180 equals negative polarity.
// R12 - outside 10..200 MHz, 90 becomes 0 and 270 becomes 180.
// R13 - fine skew relative to phase, disabled below 25 MHz.
// R14 - skew takes discrete values, range limited by clock rate.
// R15 - negative polarity moves capture by half a period to the falling edge.
// R16 - filtered or unfiltered sample type accepted.
// R17 - words read as two's complement or offset binary.
// R18 - negation goes via two's complement, times minus one, back to format.
// R19 - bit order, I/Q swap and data polarity settings apply to samples.
// R20 - enable starts realtime custom format; filter inactive for filtered type.
// R21 - indicator blinks with active data lines, solid when all lines idle.
// R22 - indicator stays lit after first enable until power is lost.
// R23 - operator disables the interface before changing data parameters.
// R24 - enable needs an active format; format loss turns off and flags error.
// R25 - each word latched on the shifted capture edge and written to the buffer.
package iqr_pkg;
   // ==================================================================
   // register map
   localparam logic [7:0]  REG_CTRL    = 8'h00;
   localparam logic [7:0]  REG_RATE    = 8'h04;
   localparam logic [7:0]  REG_SKEW    = 8'h08;
   localparam logic [7:0]  REG_DIV     = 8'h0c;
   localparam logic [7:0]  REG_STATUS  = 8'h10;
   localparam logic [7:0]  REG_ERRCODE = 8'h14;
   localparam logic [7:0]  REG_PERIOD  = 8'h18;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   localparam logic [31:0] RATE_RST    = 32'h0000_2710;
   localparam logic [3:0]  SKEW_RST    = 4'h0;
   localparam logic [15:0] DIV_RST     = 16'h0001;
   // status bit positions
   localparam int ST_OVF  = 0;
   localparam int ST_UDF  = 1;
   localparam int ST_FMT  = 2;
   localparam int ST_RUN  = 3;
   localparam int ST_LED  = 4;
   // error codes
   localparam logic [9:0]  ERR_OVF = 10'd803;
   localparam logic [9:0]  ERR_UDF = 10'd804;
   // rate limits, declared rate in kHz
   localparam logic [31:0] RATE_PH_MIN   = 32'd10000;
   localparam logic [31:0] RATE_PH_MAX   = 32'd200000;
   localparam logic [31:0] RATE_SKEW_MIN = 32'd25000;
   // timing and sizes
   localparam int CLK_KHZ  = 10000;
   localparam int BLINK_MS = 250;
   localparam int BLINK_CYC_DEF = BLINK_MS * CLK_KHZ;
   localparam int SW    = 16;
   localparam int FDEPTH = 16;
   localparam int FAW   = 4;

   typedef enum logic [1:0] {PORT_SER, PORT_PAR, PORT_ILV, PORT_RSV} iqr_port_t;
   typedef enum logic [1:0] {SRC_EXT, SRC_DEV, SRC_INT, SRC_RSV} iqr_src_t;

   // control register, bit 31 downward
   typedef struct packed {
      logic [14:0] rsv;
      logic        filt_en;
      logic        data_inv;
      logic        swap;
      logic        lsb_first;
      logic        neg_q;
      logic        neg_i;
      logic        offset_bin;
      logic        unfiltered_sample_type;
      logic [1:0]  phase;
      logic        pol_neg;
      iqr_src_t    src;
      iqr_port_t   port;
      logic        dir_out;
      logic        enable;
   } iqr_ctrl_t;

   typedef struct packed {
      logic [SW-1:0] i;
      logic [SW-1:0] q;
   } iqr_smp_t;
endpackage : iqr_pkg

// [core/iqr_rx.sv]
// receive-direction digital I/Q port: APB registers, clock pick, capture, format, buffer.
// assumes link pins asynchronous to I_CLK_SYS and link clock well below a quarter of it.
module iqr_rx
   import iqr_pkg::*;
#(
   parameter bit OPT_TX_FITTED = 1'b1,
   parameter int BLINK_CYC     = BLINK_CYC_DEF
) (
   input  wire logic          I_CLK_SYS,
   input  wire logic          I_SYS_RST,
   input  wire logic          I_PSEL,
   input  wire logic          I_PENABLE,
   input  wire logic          I_PWRITE,
   input  wire logic [7:0]    I_PADDR,
   input  wire logic [31:0]   I_PWDATA,
   output logic      [31:0]   O_PRDATA,
   output logic               O_PREADY,
   output logic               O_PSLVERR,
   input  wire logic          I_CLK_EXT,
   input  wire logic          I_CLK_DEV,
   input  wire logic          I_CLK_REF,
   input  wire logic          I_SER_SYNC,
   input  wire logic          I_SER_I,
   input  wire logic          I_SER_Q,
   input  wire logic [SW-1:0] I_PAR_I,
   input  wire logic [SW-1:0] I_PAR_Q,
   input  wire logic          I_MOD_ACTIVE,
   input  wire logic          I_BB_READY,
   output logic               O_BB_VALID,
   output iqr_smp_t           O_BB_DATA,
   output logic               O_BB_UNFILT,
   output logic               O_BB_FILTER_ON,
   output logic               O_BB_CUSTOM_RT,
   output logic               O_LED
);
   // ==================================================================
   // pin synchronisers
   localparam int NPIN = 6 + 2 * SW;
   logic [NPIN-1:0] pin_s1;
   logic [NPIN-1:0] pin_s2;
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
      end else begin
         pin_s1 <= {I_CLK_EXT, I_CLK_DEV, I_CLK_REF, I_SER_SYNC, I_SER_I, I_SER_Q,
                    I_PAR_I, I_PAR_Q};
         pin_s2 <= pin_s1;
      end
   end
   wire logic          ext_s  = pin_s2[NPIN-1];
   wire logic          dev_s  = pin_s2[NPIN-2];
   wire logic          ref_s  = pin_s2[NPIN-3];
   wire logic          sync_s = pin_s2[NPIN-4];
   wire logic          seri_s = pin_s2[NPIN-5];
   wire logic          serq_s = pin_s2[NPIN-6];
   wire logic [SW-1:0] pari_s = pin_s2[2*SW-1:SW];
   wire logic [SW-1:0] parq_s = pin_s2[SW-1:0];

   // ==================================================================
   // registers and APB slave
   iqr_ctrl_t     ctrl;
   logic [31:0]   rate;
   logic [3:0]    skew;
   logic [15:0]   div;
   logic [2:0]    sticky;
   logic [9:0]    err_code;
   logic [7:0]    period;
   logic          led_armed;
   logic          fmt_drop;
   logic          ovf_ev;
   logic          udf_ev;

   wire logic apb_setup = I_PSEL & ~I_PENABLE;
   wire logic apb_wr    = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
   wire logic sel_ctrl  = I_PADDR == REG_CTRL;
   wire logic sel_rate  = I_PADDR == REG_RATE;
   wire logic sel_skew  = I_PADDR == REG_SKEW;
   wire logic sel_div   = I_PADDR == REG_DIV;
   wire logic sel_stat  = I_PADDR == REG_STATUS;
   wire logic mapped    = sel_ctrl | sel_rate | sel_skew | sel_div | sel_stat
                        | (I_PADDR == REG_ERRCODE) | (I_PADDR == REG_PERIOD);

   // effective phase: quarter steps only inside the rate window
   wire logic       ph_ok    = (rate >= RATE_PH_MIN) && (rate <= RATE_PH_MAX);
   wire logic [1:0] phase_e  = ph_ok ? ctrl.phase : {ctrl.phase[1], 1'b0}; // [R12] [R11]
   wire logic       dir_in   = ~(OPT_TX_FITTED & ctrl.dir_out);             // [R1] [R2]
   wire logic       rx_on    = ctrl.enable & dir_in;                        // [R1]

   iqr_ctrl_t next_ctrl;
   always_comb begin
      next_ctrl = ctrl;
      if (apb_wr && sel_ctrl) begin
         next_ctrl = iqr_ctrl_t'(I_PWDATA);
         next_ctrl.rsv = '0;
         next_ctrl.enable = I_PWDATA[0] & I_MOD_ACTIVE;                     // [R24]
         if (!OPT_TX_FITTED) begin
            next_ctrl.dir_out = 1'b0;                                       // [R2]
         end
      end
      if (!I_MOD_ACTIVE) begin
         next_ctrl.enable = 1'b0;                                           // [R24]
      end
      next_ctrl.phase = (apb_wr && sel_ctrl) ? next_ctrl.phase : phase_e;   // [R12]
   end
   assign fmt_drop = ctrl.enable & ~I_MOD_ACTIVE;

   wire logic [2:0] st_set = {fmt_drop, udf_ev, ovf_ev};
   wire logic [2:0] st_clr = (apb_wr && sel_stat) ? I_PWDATA[2:0] : 3'h0;

   logic [31:0] rd_mux;
   always_comb begin
      case (I_PADDR)
         REG_CTRL:    rd_mux = ctrl;
         REG_RATE:    rd_mux = rate;
         REG_SKEW:    rd_mux = {28'h0, skew};
         REG_DIV:     rd_mux = {16'h0, div};
         REG_STATUS:  rd_mux = {27'h0, led_armed, rx_on, sticky};
         REG_ERRCODE: rd_mux = {22'h0, err_code};
         REG_PERIOD:  rd_mux = {24'h0, period};
         default:     rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         ctrl      <= iqr_ctrl_t'(CTRL_RST);
         rate      <= RATE_RST;
         skew      <= SKEW_RST;
         div       <= DIV_RST;
         sticky    <= 3'h0;
         err_code  <= 10'h0;
         O_PREADY  <= 1'b0;
         O_PRDATA  <= 32'h0;
         O_PSLVERR <= 1'b0;
      end else begin
         ctrl      <= next_ctrl;
         O_PREADY  <= apb_setup;
         O_PSLVERR <= apb_setup & ~mapped;
         O_PRDATA  <= apb_setup ? rd_mux : 32'h0;
         if (apb_wr && sel_rate) rate <= I_PWDATA;                          // [R9]
         if (apb_wr && sel_skew) skew <= I_PWDATA[3:0];
         if (apb_wr && sel_div)  div  <= I_PWDATA[15:0];
         sticky <= (sticky & ~st_clr) | st_set;   // set wins over clear
         if (ovf_ev) begin
            err_code <= ERR_OVF;                                            // [R4]
         end else if (udf_ev) begin
            err_code <= ERR_UDF;                                            // [R5]
         end
      end
   end

   // ==================================================================
   // clock source and edge finder
   logic [15:0] ref_cnt;
   logic        int_clk;
   logic        ref_d;
   logic        clk_d;
   logic [7:0]  per_cnt;
   wire logic sel_clk = (ctrl.src == SRC_EXT) ? ext_s                      // [R6]
                      : (ctrl.src == SRC_DEV) ? dev_s : int_clk;           // [R7] [R8]
   wire logic rise = sel_clk & ~clk_d;
   wire logic fall = ~sel_clk & clk_d;
   wire logic ref_rise = ref_s & ~ref_d;

   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         ref_d   <= 1'b0;
         ref_cnt <= 16'h0;
         int_clk <= 1'b0;
         clk_d   <= 1'b0;
         per_cnt <= 8'h0;
         period  <= 8'h0;
      end else begin
         ref_d <= ref_s;
         clk_d <= sel_clk;
         // internal clock toggles every div reference edges
         if (ref_rise) begin                                                // [R8] [R9]
            if (ref_cnt + 16'h1 >= div) begin
               ref_cnt <= 16'h0;
               int_clk <= ~int_clk;
            end else begin
               ref_cnt <= ref_cnt + 16'h1;
            end
         end
         if (rise) begin
            period  <= per_cnt;
            per_cnt <= 8'h1;
         end else if (per_cnt != 8'hff) begin
            per_cnt <= per_cnt + 8'h1;
         end
      end
   end

   // ==================================================================
   // capture timing: base edge, quarter step, skew
   wire logic [7:0] quarter = {2'b00, period[7:2]};
   wire logic       skew_ok = rate >= RATE_SKEW_MIN;                        // [R13]
   wire logic [7:0] skew_c  = ({4'h0, skew} > quarter) ? quarter : {4'h0, skew}; // [R14]
   wire logic [7:0] skew_e  = skew_ok ? skew_c : 8'h0;                      // [R13]
   wire logic       use_fall = phase_e[1] ^ ctrl.pol_neg;                   // [R11] [R15]
   wire logic       base_edge = use_fall ? fall : rise;                     // [R15]
   wire logic [7:0] delay = (phase_e[0] ? quarter : 8'h0) + skew_e;         // [R11] [R13]
   logic [7:0] dly_cnt;
   logic       pend;
   wire logic  cap = rx_on & ((base_edge && delay == 8'h0)
                             || (pend && dly_cnt == 8'h1));                // [R25]

   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         dly_cnt <= 8'h0;
         pend    <= 1'b0;
      end else if (base_edge && delay != 8'h0) begin
         dly_cnt <= delay;
         pend    <= 1'b1;
      end else if (pend) begin
         dly_cnt <= dly_cnt - 8'h1;
         pend    <= dly_cnt != 8'h1;
      end
   end

   // ==================================================================
   // word assembly per port mode
   logic [SW-1:0] sh_i;
   logic [SW-1:0] sh_q;
   logic [3:0]    bit_cnt;
   logic          ilv_q;
   logic          word_ev;
   iqr_smp_t      raw;

   wire logic [3:0] bit_n = (sync_s ? 4'h0 : bit_cnt);
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         sh_i    <= '0;
         sh_q    <= '0;
         bit_cnt <= 4'h0;
         ilv_q   <= 1'b0;
         word_ev <= 1'b0;
         raw     <= '0;
      end else begin
         word_ev <= 1'b0;
         if (!rx_on) begin
            bit_cnt <= 4'h0;
            ilv_q   <= 1'b0;
         end else if (cap) begin
            case (ctrl.port)                                                // [R3]
               PORT_SER: begin
                  sh_i    <= {sh_i[SW-2:0], seri_s};
                  sh_q    <= {sh_q[SW-2:0], serq_s};
                  bit_cnt <= bit_n + 4'h1;
                  if (bit_n == 4'hf) begin
                     raw     <= '{i: {sh_i[SW-2:0], seri_s}, q: {sh_q[SW-2:0], serq_s}};
                     word_ev <= 1'b1;
                  end
               end
               PORT_PAR: begin
                  raw     <= '{i: pari_s, q: parq_s};
                  word_ev <= 1'b1;
               end
               PORT_ILV: begin
                  ilv_q <= ~ilv_q;
                  if (ilv_q) begin
                     raw.q   <= pari_s;
                     word_ev <= 1'b1;
                  end else begin
                     raw.i <= pari_s;
                  end
               end
               default: begin
                  word_ev <= 1'b0;
               end
            endcase
         end
      end
   end

   // ==================================================================
   // sample shaping
   // settings passed in so the continuous assignments below follow every control change
   function automatic logic [SW-1:0] shape(input logic [SW-1:0] w, input logic neg,
                                           input iqr_ctrl_t c);
      logic [SW-1:0] v;
      v = w;
      if (c.lsb_first) begin                                                // [R19]
         for (int k = 0; k < SW; k++) v[k] = w[SW-1-k];
      end
      if (c.data_inv) v = ~v;                                               // [R19]
      if (neg) begin                                                        // [R18]
         if (c.offset_bin) v[SW-1] = ~v[SW-1];                              // [R17]
         v = SW'(~v + 1'b1);
         if (c.offset_bin) v[SW-1] = ~v[SW-1];
      end
      return v;
   endfunction : shape

   wire logic [SW-1:0] s_i = shape(raw.i, ctrl.neg_i, ctrl);
   wire logic [SW-1:0] s_q = shape(raw.q, ctrl.neg_q, ctrl);
   wire iqr_smp_t      wsmp = ctrl.swap ? '{i: s_q, q: s_i} : '{i: s_i, q: s_q}; // [R19]

   // ==================================================================
   // input buffer
   logic [FAW:0] wptr;
   logic [FAW:0] rptr;
   logic         started;
   wire logic full  = (wptr[FAW] != rptr[FAW]) && (wptr[FAW-1:0] == rptr[FAW-1:0]);
   wire logic empty = wptr == rptr;
   wire logic wr_en = word_ev & ~full;                                      // [R25]
   wire logic rd_en = ~empty & (~O_BB_VALID | I_BB_READY);
   assign ovf_ev = word_ev & full;                                          // [R4]
   assign udf_ev = rx_on & started & I_BB_READY & ~O_BB_VALID;              // [R5]

   iqr_mem u_mem (
      .i_clk   (I_CLK_SYS),
      .i_we    (wr_en),
      .i_waddr (wptr[FAW-1:0]),
      .i_wdata (wsmp),
      .i_re    (rd_en),
      .i_raddr (rptr[FAW-1:0]),
      .o_rdata (O_BB_DATA)
   );

   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         wptr       <= '0;
         rptr       <= '0;
         O_BB_VALID <= 1'b0;
         started    <= 1'b0;
      end else begin
         if (wr_en) wptr <= wptr + 1'b1;
         if (rd_en) rptr <= rptr + 1'b1;
         if (rd_en) begin
            O_BB_VALID <= 1'b1;
         end else if (I_BB_READY) begin
            O_BB_VALID <= 1'b0;
         end
         started <= rx_on & (started | wr_en);
      end
   end

   // ==================================================================
   // baseband control and activity indicator
   logic [31:0]   blink_cnt;
   logic          blink_ph;
   logic          act_seen;
   logic          act_prev;
   logic [NPIN-4:0] data_d;
   wire logic [NPIN-4:0] data_now = pin_s2[NPIN-4:0];
   wire logic blink_wrap = blink_cnt == 32'(BLINK_CYC - 1);

   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_BB_UNFILT    <= 1'b0;
         O_BB_FILTER_ON <= 1'b0;
         O_BB_CUSTOM_RT <= 1'b0;
         O_LED          <= 1'b0;
         led_armed      <= 1'b0;
         blink_cnt      <= 32'h0;
         blink_ph       <= 1'b0;
         act_seen       <= 1'b0;
         act_prev       <= 1'b0;
         data_d         <= '0;
      end else begin
         O_BB_UNFILT    <= ctrl.unfiltered_sample_type;                     // [R16]
         O_BB_FILTER_ON <= ctrl.filt_en & ctrl.unfiltered_sample_type;      // [R20]
         O_BB_CUSTOM_RT <= rx_on;                                           // [R20]
         led_armed      <= led_armed | rx_on;                               // [R22]
         data_d         <= data_now;
         blink_cnt      <= blink_wrap ? 32'h0 : blink_cnt + 32'h1;
         if (blink_wrap) begin
            blink_ph <= ~blink_ph;
            act_prev <= act_seen | (data_now != data_d);
            act_seen <= 1'b0;
         end else if (data_now != data_d) begin
            act_seen <= 1'b1;
         end
         O_LED <= led_armed & (act_prev ? blink_ph : 1'b1);                 // [R21] [R22]
      end
   end

   // ==================================================================
   // checks
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_SYS_RST);

   sequence s_setup;  I_PSEL && !I_PENABLE;  endsequence
   sequence s_access; I_PSEL && I_PENABLE && O_PREADY; endsequence
   sequence s_led_idle; led_armed ##1 !act_prev; endsequence

   AST_APB_ONE_WAIT: assert property (s_setup |=> O_PREADY)
      else $error("pready missing after setup");
   AST_ENA_NEEDS_FMT: assert property (!I_MOD_ACTIVE |=> !ctrl.enable) // [R24]
      else $error("enable held without active format");
   AST_FMT_ERR: assert property (ctrl.enable && !I_MOD_ACTIVE |=> sticky[ST_FMT]) // [R24]
      else $error("format loss not flagged");
   AST_OVF_CODE: assert property (word_ev && full |=> sticky[ST_OVF] && err_code == ERR_OVF) // [R4]
      else $error("overflow not reported as 803");
   AST_UDF_FLAG: assert property (udf_ev |=> sticky[ST_UDF]) // [R5]
      else $error("underflow not flagged");
   AST_PHASE_COERCE: assert property (!ph_ok && !(apb_wr && sel_ctrl) // [R12]
      |=> !ctrl.phase[0])
      else $error("quarter phase used outside rate window");
   AST_SKEW_OFF: assert property (!skew_ok && base_edge && !phase_e[0] |-> cap || !rx_on) // [R13]
      else $error("skew applied below 25 MHz");
   AST_RX_ONLY: assert property (!OPT_TX_FITTED |-> !ctrl.dir_out) // [R2]
      else $error("direction set without transmit option");
   AST_FILTER_GATE: assert property (!ctrl.unfiltered_sample_type |=> !O_BB_FILTER_ON) // [R20]
      else $error("filter active for filtered samples");
   AST_LED_STAYS: assert property (s_led_idle |=> O_LED) // [R22]
      else $error("indicator dark while armed and idle");
   AST_FULL_NO_WRITE: assert property (word_ev && full |=> $stable(wptr)) // [R25]
      else $error("write into full buffer");
   AST_PAR_WORD: assert property (cap && ctrl.port == PORT_PAR && rx_on |=> word_ev) // [R3]
      else $error("parallel capture produced no word");
endmodule : iqr_rx

// [dv/iqr_dev.sv]
// device-side model: drives the device clock and the parallel I/Q buses.
// assumes the bench calls send() once per word; clock idles low between words.
module iqr_dev
   import iqr_pkg::*;
(
   output logic          o_clk,
   output logic [SW-1:0] o_i,
   output logic [SW-1:0] o_q
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_clk = 1'b0;
      o_i   = '0;
      o_q   = '0;
   end
   // ==================================================================
   // one 800 ns frame, word held well across the rising edge
   task automatic send(input iqr_smp_t w);
      #13;
      o_i = w.i;
      o_q = w.q;
      #200 o_clk = 1'b1;
      #400 o_clk = 1'b0;
      // hold over: show the inverse so a late capture cannot pass
      o_i = ~w.i;
      o_q = ~w.q;
      #187;
   endtask : send
endmodule : iqr_dev

// [dv/iqr_rx_tb.sv]
// self-checking bench for iqr_rx: APB set-up, parallel words from iqr_dev.
// assumes a 10 MHz system clock; external and serial pins held idle, reference free-running.
module iqr_rx_tb
   import iqr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic          clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic          mod_act = 1'b0, bb_rdy = 1'b0, refc = 1'b0;
   logic [7:0]    paddr = '0;
   logic [31:0]   pwdata = '0, prdata;
   logic          pready, pslverr, bb_valid, unfilt, filt_on, cust_rt, led, dclk;
   logic [SW-1:0] di, dq;
   iqr_smp_t      bb_data;
   logic [64:0]   rq[$];
   iqr_smp_t      xq[$];
   int            failures = 0, checked = 0, led_low = 0;
   // unused external clock left undriven-low
   iqr_rx #(.BLINK_CYC(16)) u_dut (
      .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .I_CLK_EXT(1'b0), .I_CLK_DEV(dclk), .I_CLK_REF(refc),
      .I_SER_SYNC(1'b0), .I_SER_I(1'b0), .I_SER_Q(1'b0), .I_PAR_I(di), .I_PAR_Q(dq),
      .I_MOD_ACTIVE(mod_act), .I_BB_READY(bb_rdy), .O_BB_VALID(bb_valid),
      .O_BB_DATA(bb_data), .O_BB_UNFILT(unfilt), .O_BB_FILTER_ON(filt_on),
      .O_BB_CUSTOM_RT(cust_rt), .O_LED(led));
   iqr_dev u_dev (.o_clk(dclk), .o_i(di), .o_q(dq));
   // ==================================================================
   // shared tasks
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pen    <= 1'b0;
      pwr    <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      // no cycle limit here: a hang is caught by the watchdog
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input logic err = 1'b0);
      rq.push_back({err, m, e});
      apb(1'b0, a, '0);
   endtask : rd
   function automatic iqr_smp_t model(input iqr_smp_t w, input logic [31:0] c);
      iqr_smp_t      r;
      logic [SW-1:0] m;
      r = w;
      for (int b = 0; b < SW; b++) begin
         if (c[13]) r.i[b] = w.i[SW-1-b];
         if (c[13]) r.q[b] = w.q[SW-1-b];
      end
      if (c[15]) r = ~r;
      // offset binary: sign bit flipped around the two's complement negation
      m = c[10] ? 16'h8000 : 16'h0;
      if (c[11]) r.i = -(r.i ^ m) ^ m;
      if (c[12]) r.q = -(r.q ^ m) ^ m;
      return c[14] ? {r.q, r.i} : r;
   endfunction : model
   task automatic final_report();
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report
   // ==================================================================
   // clock, watchdog, result monitor
   initial begin
      forever #50 clk = ~clk;
   end
   // free-running frequency reference, 800 ns period
   initial begin
      forever #400 refc = ~refc;
   end
   initial begin
      #1ms;
      failures++;
      final_report();
   end
   always @(posedge clk) begin : mon
      logic [64:0] e;
      if (cust_rt && led === 1'b0) led_low++;
      if (psel && pen && pready && !pwr && rq.size() > 0) begin
         e = rq.pop_front();
         chk({pslverr, prdata & e[63:32]}, {e[64], e[31:0]});
      end
      if (bb_valid && bb_rdy && xq.size() > 0)
         chk({1'b0, bb_data}, {1'b0, xq.pop_front()});
   end
   // ==================================================================
   // main sequence
   initial begin : main
      logic [31:0] cfg[5];
      cfg = '{32'h0001_0015, 32'h0000_6015, 32'h0000_1c15, 32'h0001_8215, 32'h0000_0019};
      void'($urandom(1));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(REG_RATE, '1, RATE_RST);
      rd(8'h20, '1, '0, 1'b1);
      for (int p = 1; p < 4; p += 2) begin
         wr_ctrl: apb(1'b1, REG_CTRL, 32'(p) << 7);
         apb(1'b1, REG_RATE, 32'd5000);
         rd(REG_CTRL, 32'h180, 32'(p & 2) << 7);
      end
      // internal source: DIV_RST reference edges per half period, reference 8 cycles
      apb(1'b1, REG_CTRL, 32'h20);
      repeat (40) @(posedge clk);
      rd(REG_PERIOD, 32'hff, 32'h10);
      apb(1'b1, REG_RATE, RATE_RST);
      apb(1'b1, REG_CTRL, cfg[0]);
      rd(REG_CTRL, 32'h1, '0);
      mod_act <= 1'b1;
      bb_rdy  <= 1'b1;
      foreach (cfg[k]) begin
         apb(1'b1, REG_CTRL, '0);
         apb(1'b1, REG_CTRL, cfg[k]);
         repeat (2) @(posedge clk);
         chk({cust_rt, unfilt, filt_on}, {1'b1, cfg[k][9], cfg[k][9] & cfg[k][16]});
         repeat (4) begin
            iqr_smp_t w;
            w = iqr_smp_t'($urandom);
            xq.push_back(model(w, cfg[k]));
            u_dev.send(w);
            // interleaved: the second frame carries Q on the I bus
            if (cfg[k][3]) u_dev.send({w.q, w.i});
         end
         repeat (8) @(posedge clk);
      end
      chk(xq.size(), 0);
      chk(led_low > 8, 1'b1);
      rd(REG_ERRCODE, 32'h3ff, 32'(ERR_UDF));
      mod_act <= 1'b0;
      repeat (3) @(posedge clk);
      rd(REG_STATUS, 32'h1c, 32'h14);
      rd(REG_CTRL, 32'h1, '0);
      mod_act <= 1'b1;
      bb_rdy  <= 1'b0;
      apb(1'b1, REG_CTRL, cfg[0]);
      repeat (FDEPTH + 3) u_dev.send(iqr_smp_t'($urandom));
      rd(REG_ERRCODE, 32'h3ff, 32'(ERR_OVF));
      // data lines now idle: indicator must settle to solid
      repeat (40) @(posedge clk);
      repeat (20) begin
         @(posedge clk);
         chk(led, 1'b1);
      end
      final_report();
   end
endmodule : iqr_rx_tb
